// ### rtl/bwalu_map.svh
// constant map of the byte/word arithmetic and logic unit
`ifndef BWALU_MAP_SVH
`define BWALU_MAP_SVH

// flag register layout
`define BWALU_FLAG_C 0
`define BWALU_FLAG_V 1
`define BWALU_FLAG_Z 2
`define BWALU_FLAG_N 3
`define BWALU_FLAG_H 5
`define BWALU_FLAG_RESET 8'h00

// constants used by the datapath
`define BWALU_BYTE_ZERO 8'h00
`define BWALU_WORD_ZERO 16'h0000
`define BWALU_ONE_BYTE 8'h01
`define BWALU_ONE_WORD 16'h0001
`define BWALU_TWO_WORD 16'h0002

// decimal adjust
`define BWALU_BCD_DIGIT_MAX 4'h9
`define BWALU_BCD_BYTE_MAX 8'h99
`define BWALU_BCD_LO_FIX 8'h06
`define BWALU_BCD_HI_FIX 8'h60

// divider
`define BWALU_DIV_STEPS 4'h8
`define BWALU_DIV_LAST 4'h1
`define BWALU_DIV_IDLE 4'h0

`endif

// ### rtl/bwalu_pkg.sv
// types of the byte/word arithmetic and logic unit
package bwalu_pkg;

    typedef enum logic [4:0] {
        op_plus,
        op_minus,
        op_add_with_carry,
        op_subtract_with_borrow,
        op_plus_one,
        op_minus_one,
        op_word_small_increment,
        op_word_small_decrement,
        op_bcd_fix_after_plus,
        op_bcd_fix_after_minus,
        op_unsigned_multiply,
        op_unsigned_divide,
        op_compare,
        op_twos_complement,
        op_and,
        op_or,
        op_xor,
        op_not
    } bwalu_op_t;

    typedef enum logic [0:0] {
        st_idle,
        st_div_wait
    } bwalu_state_t;

endpackage

// ### rtl/bwalu_bcd_fix.sv
// decimal adjust of a byte after an addition or a subtraction
`timescale 1ns/1ps
`include "bwalu_map.svh"

module bwalu_bcd_fix
    import bwalu_pkg::*;
(
    input wire logic [7:0] i_value,
    input wire logic i_carry,
    input wire logic i_half,
    input wire logic i_minus,
    output logic [7:0] o_value,
    output logic o_carry
);

    logic lo_fix;
    logic hi_fix;
    logic [7:0] fix;

    always_comb begin
        // after a subtraction only the borrows say where a digit went wrong
        if (i_minus) begin
            lo_fix = i_half;
            hi_fix = i_carry;
        end else begin
            lo_fix = i_half || (i_value[3:0] > `BWALU_BCD_DIGIT_MAX);
            hi_fix = i_carry || (i_value > `BWALU_BCD_BYTE_MAX);
        end
        fix = (lo_fix ? `BWALU_BCD_LO_FIX : `BWALU_BYTE_ZERO) | (hi_fix ? `BWALU_BCD_HI_FIX : `BWALU_BYTE_ZERO);
        o_value = i_minus ? (i_value - fix) : (i_value + fix);
        o_carry = hi_fix;
    end

endmodule

// ### rtl/bwalu_divider.sv
// restoring 16 by 8 unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`include "bwalu_map.svh"

module bwalu_divider
    import bwalu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [15:0] i_dividend,
    input wire logic [7:0] i_divisor,
    output logic o_done,
    output logic [7:0] o_quotient,
    output logic [7:0] o_remainder
);

    logic [7:0] rem_r;
    logic [7:0] quo_r;
    logic [7:0] div_r;
    logic [3:0] cnt_r;
    logic done_r;
    logic [8:0] trial;
    logic [8:0] diff;
    logic fits;

    always_comb begin
        trial = {rem_r, quo_r[7]};
        diff = trial - {1'b0, div_r};
        fits = (trial >= {1'b0, div_r});
    end

    // ****************************************
    // iteration
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            rem_r <= `BWALU_BYTE_ZERO;
            quo_r <= `BWALU_BYTE_ZERO;
            div_r <= `BWALU_BYTE_ZERO;
            cnt_r <= `BWALU_DIV_IDLE;
            done_r <= 1'b0;
        end else if (i_start) begin
            rem_r <= i_dividend[15:8];
            quo_r <= i_dividend[7:0];
            div_r <= i_divisor;
            cnt_r <= `BWALU_DIV_STEPS;
            done_r <= 1'b0;
        end else if (cnt_r != `BWALU_DIV_IDLE) begin
            rem_r <= fits ? diff[7:0] : trial[7:0];
            quo_r <= {quo_r[6:0], fits};
            cnt_r <= cnt_r - `BWALU_DIV_LAST;
            done_r <= (cnt_r == `BWALU_DIV_LAST);
        end else begin
            done_r <= 1'b0;
        end
    end

    assign o_done = done_r;
    assign o_quotient = quo_r;
    assign o_remainder = rem_r;

endmodule

// ### rtl/bwalu_core.sv
// byte/word arithmetic and logic execution datapath with its flag register
`timescale 1ns/1ps
`include "bwalu_map.svh"

module bwalu_core
    import bwalu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire bwalu_op_t i_op,
    input wire logic i_word,
    input wire logic i_use_imm,
    input wire logic [15:0] i_dst,
    input wire logic [15:0] i_src,
    input wire logic [15:0] i_imm,
    output logic o_busy,
    output logic o_done,
    output logic o_write,
    output logic o_illegal,
    output logic [15:0] o_result,
    output logic [7:0] o_flags
);

    // ****************************************
    // adders
    // ****************************************
    // returns {h, v, c, sum}
    function automatic logic [10:0] arith8(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [8:0] full;
        logic [4:0] half;
        logic v;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
            v = (a[7] != b[7]) && (full[7] != a[7]);
        end else begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
            v = (a[7] == b[7]) && (full[7] != a[7]);
        end
        return {half[4], v, full[8], full[7:0]};
    endfunction

    // returns {h, v, c, sum}
    function automatic logic [18:0] arith16(input logic [15:0] a, input logic [15:0] b, input logic sub);
        logic [16:0] full;
        logic [12:0] half;
        logic v;
        if (sub) begin
            full = {1'b0, a} - {1'b0, b};
            half = {1'b0, a[11:0]} - {1'b0, b[11:0]};
            v = (a[15] != b[15]) && (full[15] != a[15]);
        end else begin
            full = {1'b0, a} + {1'b0, b};
            half = {1'b0, a[11:0]} + {1'b0, b[11:0]};
            v = (a[15] == b[15]) && (full[15] != a[15]);
        end
        return {half[12], v, full[16], full[15:0]};
    endfunction

    // ****************************************
    // state
    // ****************************************
    bwalu_state_t state_r;
    logic [7:0] flag_r;
    logic [15:0] result_r;
    logic done_r;
    logic write_r;
    logic illegal_r;

    logic [7:0] flags_nxt;
    logic [15:0] res_nxt;
    logic wr_nxt;
    logic illegal_nxt;
    logic div_go;

    logic [15:0] opb;
    logic [10:0] r8;
    logic [18:0] r16;
    logic [7:0] bcd_val;
    logic bcd_carry;
    logic div_done;
    logic [7:0] div_quo;
    logic [7:0] div_rem;
    logic take;

    // a request seen while the divider runs is dropped, not queued
    assign take = i_start && (state_r == st_idle);
    assign opb = i_use_imm ? i_imm : i_src;

    // ****************************************
    // sub units
    // ****************************************
    bwalu_bcd_fix u_bcd (
        .i_value(i_dst[7:0]),
        .i_carry(flag_r[`BWALU_FLAG_C]),
        .i_half(flag_r[`BWALU_FLAG_H]),
        .i_minus(i_op == op_bcd_fix_after_minus),
        .o_value(bcd_val),
        .o_carry(bcd_carry)
    );

    bwalu_divider u_div (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(take && div_go),
        .i_dividend(i_dst),
        .i_divisor(i_src[7:0]),
        .o_done(div_done),
        .o_quotient(div_quo),
        .o_remainder(div_rem)
    );

    // ****************************************
    // operation decode and result
    // ****************************************
    always_comb begin
        flags_nxt = flag_r;
        res_nxt = i_dst;
        wr_nxt = 1'b0;
        illegal_nxt = 1'b0;
        div_go = 1'b0;
        r8 = arith8(i_dst[7:0], opb[7:0], 1'b0, 1'b0);
        r16 = arith16(i_dst, opb, 1'b0);
        // everything but the plain, compare and small word step forms is byte only
        if (i_word && !(i_op == op_plus || i_op == op_minus || i_op == op_compare
                        || i_op == op_word_small_increment || i_op == op_word_small_decrement)) begin
            illegal_nxt = 1'b1;
        end else begin
            case (i_op)
                op_plus, op_minus, op_compare: begin
                    if (i_use_imm && (i_op == op_minus)) begin
                        illegal_nxt = 1'b1;
                    end else if (i_use_imm && i_word) begin
                        illegal_nxt = 1'b1;
                    end else if (i_word) begin
                        r16 = arith16(i_dst, opb, i_op != op_plus);
                        res_nxt = r16[15:0];
                        wr_nxt = (i_op != op_compare);
                        flags_nxt[`BWALU_FLAG_H] = r16[18];
                        flags_nxt[`BWALU_FLAG_V] = r16[17];
                        flags_nxt[`BWALU_FLAG_C] = r16[16];
                        flags_nxt[`BWALU_FLAG_N] = r16[15];
                        flags_nxt[`BWALU_FLAG_Z] = (r16[15:0] == `BWALU_WORD_ZERO);
                    end else begin
                        r8 = arith8(i_dst[7:0], opb[7:0], 1'b0, i_op != op_plus);
                        res_nxt = {i_dst[15:8], r8[7:0]};
                        wr_nxt = (i_op != op_compare);
                        flags_nxt[`BWALU_FLAG_H] = r8[10];
                        flags_nxt[`BWALU_FLAG_V] = r8[9];
                        flags_nxt[`BWALU_FLAG_C] = r8[8];
                        flags_nxt[`BWALU_FLAG_N] = r8[7];
                        flags_nxt[`BWALU_FLAG_Z] = (r8[7:0] == `BWALU_BYTE_ZERO);
                    end
                end
                op_add_with_carry, op_subtract_with_borrow: begin
                    r8 = arith8(i_dst[7:0], opb[7:0], flag_r[`BWALU_FLAG_C],
                                i_op == op_subtract_with_borrow);
                    res_nxt = {i_dst[15:8], r8[7:0]};
                    wr_nxt = 1'b1;
                    flags_nxt[`BWALU_FLAG_H] = r8[10];
                    flags_nxt[`BWALU_FLAG_V] = r8[9];
                    flags_nxt[`BWALU_FLAG_C] = r8[8];
                    flags_nxt[`BWALU_FLAG_N] = r8[7];
                    // zero only kept, so a multi-byte chain tests zero over all bytes
                    if (r8[7:0] != `BWALU_BYTE_ZERO) begin
                        flags_nxt[`BWALU_FLAG_Z] = 1'b0;
                    end
                end
                op_plus_one, op_minus_one, op_twos_complement: begin
                    if (i_op == op_twos_complement) begin
                        r8 = arith8(`BWALU_BYTE_ZERO, i_dst[7:0], 1'b0, 1'b1);
                        flags_nxt[`BWALU_FLAG_H] = r8[10];
                        flags_nxt[`BWALU_FLAG_C] = r8[8];
                    end else begin
                        r8 = arith8(i_dst[7:0], `BWALU_ONE_BYTE, 1'b0, i_op == op_minus_one);
                    end
                    res_nxt = {i_dst[15:8], r8[7:0]};
                    wr_nxt = 1'b1;
                    flags_nxt[`BWALU_FLAG_V] = r8[9];
                    flags_nxt[`BWALU_FLAG_N] = r8[7];
                    flags_nxt[`BWALU_FLAG_Z] = (r8[7:0] == `BWALU_BYTE_ZERO);
                end
                op_word_small_increment, op_word_small_decrement: begin
                    // address arithmetic: flags stay as they were
                    if (i_imm != `BWALU_ONE_WORD && i_imm != `BWALU_TWO_WORD) begin
                        illegal_nxt = 1'b1;
                    end else begin
                        r16 = arith16(i_dst, i_imm, i_op == op_word_small_decrement);
                        res_nxt = r16[15:0];
                        wr_nxt = 1'b1;
                    end
                end
                op_bcd_fix_after_plus, op_bcd_fix_after_minus: begin
                    res_nxt = {i_dst[15:8], bcd_val};
                    wr_nxt = 1'b1;
                    flags_nxt[`BWALU_FLAG_C] = bcd_carry;
                    flags_nxt[`BWALU_FLAG_N] = bcd_val[7];
                    flags_nxt[`BWALU_FLAG_Z] = (bcd_val == `BWALU_BYTE_ZERO);
                end
                op_unsigned_multiply: begin
                    // widen first so the product is not cut to eight bits
                    res_nxt = {8'h00, i_dst[7:0]} * {8'h00, i_src[7:0]};
                    wr_nxt = 1'b1;
                end
                op_unsigned_divide: begin
                    // a zero divisor leaves the register alone and flags it
                    flags_nxt[`BWALU_FLAG_N] = i_src[7];
                    flags_nxt[`BWALU_FLAG_Z] = (i_src[7:0] == `BWALU_BYTE_ZERO);
                    flags_nxt[`BWALU_FLAG_V] = (i_dst[15:8] >= i_src[7:0]);
                    div_go = (i_src[7:0] != `BWALU_BYTE_ZERO);
                end
                op_and: begin
                    res_nxt = {i_dst[15:8], i_dst[7:0] & opb[7:0]};
                    wr_nxt = 1'b1;
                end
                op_or: begin
                    res_nxt = {i_dst[15:8], i_dst[7:0] | opb[7:0]};
                    wr_nxt = 1'b1;
                end
                op_xor: begin
                    res_nxt = {i_dst[15:8], i_dst[7:0] ^ opb[7:0]};
                    wr_nxt = 1'b1;
                end
                op_not: begin
                    res_nxt = {i_dst[15:8], ~i_dst[7:0]};
                    wr_nxt = 1'b1;
                end
                default: begin
                    illegal_nxt = 1'b1;
                end
            endcase
            // logic forms: n and z from the byte, v cleared, c kept
            if (i_op == op_and || i_op == op_or || i_op == op_xor || i_op == op_not) begin
                flags_nxt[`BWALU_FLAG_N] = res_nxt[7];
                flags_nxt[`BWALU_FLAG_Z] = (res_nxt[7:0] == `BWALU_BYTE_ZERO);
                flags_nxt[`BWALU_FLAG_V] = 1'b0;
            end
        end
        if (illegal_nxt) begin
            flags_nxt = flag_r;
            res_nxt = i_dst;
            wr_nxt = 1'b0;
            div_go = 1'b0;
        end
    end

    // ****************************************
    // sequencing
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            state_r <= st_idle;
        end else begin
            case (state_r)
                st_idle: begin
                    if (take && div_go) begin
                        state_r <= st_div_wait;
                    end
                end
                st_div_wait: begin
                    if (div_done) begin
                        state_r <= st_idle;
                    end
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // ****************************************
    // flag register
    // ****************************************
    // flags move at the take edge, so a divide shows them before its done
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            flag_r <= `BWALU_FLAG_RESET;
        end else if (take) begin
            flag_r <= flags_nxt;
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            result_r <= `BWALU_WORD_ZERO;
        end else if (state_r == st_div_wait && div_done) begin
            result_r <= {div_rem, div_quo};
        end else if (take && !div_go) begin
            result_r <= res_nxt;
        end
    end

    // ****************************************
    // completion pulses
    // ****************************************
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            done_r <= 1'b0;
            write_r <= 1'b0;
            illegal_r <= 1'b0;
        end else if (state_r == st_div_wait) begin
            done_r <= div_done;
            write_r <= div_done;
            illegal_r <= 1'b0;
        end else begin
            done_r <= take && !div_go;
            write_r <= take && !div_go && wr_nxt;
            illegal_r <= take && illegal_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_busy = (state_r != st_idle);
    assign o_done = done_r;
    assign o_write = write_r;
    assign o_illegal = illegal_r;
    assign o_result = result_r;
    assign o_flags = flag_r;

endmodule

// ### dv/bwalu_core_chk.sv
// concurrent checks on the ports of the alu core
`timescale 1ns/1ps
module bwalu_core_chk
    import bwalu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire bwalu_op_t i_op,
    input wire logic i_word,
    input wire logic i_use_imm,
    input wire logic [15:0] i_dst,
    input wire logic [15:0] i_src,
    input wire logic [15:0] i_imm,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_write,
    input wire logic o_illegal,
    input wire logic [15:0] o_result,
    input wire logic [7:0] o_flags
);
    // ************
    // checks
    // ************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic take;
    assign take = i_start && !o_busy;
    write_has_done_a: assert property (o_write |-> o_done) else $error("write without done");
    refuse_no_wr_a: assert property (o_illegal |-> o_done && !o_write) else $error("refused op wrote");
    quick_answer_a: assert property (take && i_op != op_unsigned_divide |=> o_done)
        else $error("late done");
    div_latency_a: assert property (take && i_op == op_unsigned_divide && !i_word && i_src[7:0] != 8'h00
        |=> o_busy [*8] ##[1:2] (o_done && o_write)) else $error("divide timing wrong");
    mul_product_a: assert property (take && i_op == op_unsigned_multiply && !i_word
        |=> o_result == {8'h00, $past(i_dst[7:0])} * {8'h00, $past(i_src[7:0])}) else $error("bad product");
    cmp_no_write_a: assert property (take && i_op == op_compare |=> o_done && !o_write)
        else $error("compare wrote");
    sub_imm_refused_a: assert property (take && i_op == op_minus && i_use_imm |=> o_illegal)
        else $error("subtract immediate taken");
    word_imm_refused_a: assert property (take && i_word && i_use_imm && (i_op == op_plus || i_op == op_compare)
        |=> o_illegal) else $error("word immediate taken");
    small_const_a: assert property (take && (i_op == op_word_small_increment || i_op == op_word_small_decrement)
        && i_imm != 16'h0001 && i_imm != 16'h0002 |=> o_illegal) else $error("bad small constant taken");
    not_invert_a: assert property (take && i_op == op_not && !i_word
        |=> o_result == {$past(i_dst[15:8]), ~$past(i_dst[7:0])}) else $error("bad complement");
    neg_value_a: assert property (take && i_op == op_twos_complement && !i_word
        |=> o_result[7:0] == 8'h00 - $past(i_dst[7:0])) else $error("bad negate");
    cover property (take && i_op == op_unsigned_divide);
    cover property (o_illegal);
    cover property (take && i_op == op_add_with_carry);
endmodule

bind bwalu_core bwalu_core_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_start(i_start), .i_op(i_op),
    .i_word(i_word), .i_use_imm(i_use_imm), .i_dst(i_dst), .i_src(i_src), .i_imm(i_imm), .o_busy(o_busy),
    .o_done(o_done), .o_write(o_write), .o_illegal(o_illegal), .o_result(o_result), .o_flags(o_flags));

// ### dv/bwalu_partner.sv
// decoder and register file model feeding the alu
`timescale 1ns/1ps
module bwalu_partner
    import bwalu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_done,
    input wire logic i_write,
    input wire logic i_illegal,
    input wire logic [15:0] i_result,
    input wire logic [7:0] i_flags,
    output logic o_start,
    output bwalu_op_t o_op,
    output logic o_word,
    output logic o_use_imm,
    output logic [15:0] o_dst,
    output logic [15:0] o_src,
    output logic [15:0] o_imm
);
    // ************
    // request issue
    // ************
    initial begin
        o_start = 1'b0;
        o_op = op_plus;
        o_word = 1'b0;
        o_use_imm = 1'b0;
        o_dst = 16'h0000;
        o_src = 16'h0000;
        o_imm = 16'h0000;
    end
    task automatic run(input bwalu_op_t op, input logic w, input logic u, input logic [15:0] d, input logic [15:0] s,
        input logic [15:0] m, output logic [15:0] res, output logic [7:0] flg, output logic wr, output logic ill,
        output logic ok);
        int n;
        ok = 1'b0;
        @(negedge i_clock);
        o_start = 1'b1;
        o_op = op;
        o_word = w;
        o_use_imm = u;
        o_dst = d;
        o_src = s;
        o_imm = m;
        @(negedge i_clock);
        o_start = 1'b0;
        // released operand lines must not keep their old value
        o_dst = ~d;
        o_src = ~s;
        o_imm = ~m;
        for (n = 0; n < 20 && !ok; n++) begin
            if (i_done === 1'b1) begin
                ok = 1'b1;
                res = i_result;
                flg = i_flags;
                wr = i_write;
                ill = i_illegal;
            end else begin
                @(negedge i_clock);
            end
        end
    endtask
endmodule

// ### dv/byte_word_arith_logic_alu_tb.sv
// self-checking bench of the alu core
`timescale 1ns/1ps
`include "bwalu_map.svh"
module byte_word_arith_logic_alu_tb
    import bwalu_pkg::*;
;
    // ************
    // bench
    // ************
    logic clock, rst_n, start, word, use_imm, busy, done, write, illegal, r_wr, r_ill, r_ok;
    bwalu_op_t op;
    logic [15:0] dst, src, imm, result, r_res;
    logic [7:0] flags, r_flg, keep;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    bwalu_core DUT (.i_clock(clock), .i_rst_n(rst_n), .i_start(start), .i_op(op), .i_word(word),
        .i_use_imm(use_imm), .i_dst(dst), .i_src(src), .i_imm(imm), .o_busy(busy), .o_done(done),
        .o_write(write), .o_illegal(illegal), .o_result(result), .o_flags(flags));
    bwalu_partner P (.i_clock(clock), .i_done(done), .i_write(write), .i_illegal(illegal), .i_result(result),
        .i_flags(flags), .o_start(start), .o_op(op), .o_word(word), .o_use_imm(use_imm), .o_dst(dst),
        .o_src(src), .o_imm(imm));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        // ceiling well above the hundred or so cycles the run needs
        if (cycles == 5000) begin
            failures++;
            $display("FAIL %0t timeout", $time);
            close_out();
        end
    end
    task close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task cmp_val(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task go(input bwalu_op_t o, input logic w, input logic u, input logic [15:0] d, input logic [15:0] s,
        input logic [15:0] m);
        P.run(o, w, u, d, s, m, r_res, r_flg, r_wr, r_ill, r_ok);
        cmp_bit(r_ok, 1'b1);
    endtask
    task wrote(input logic [15:0] exp);
        cmp_val(r_res, exp);
        cmp_bit(r_wr, 1'b1);
    endtask
    task refused(input bwalu_op_t o, input logic w, input logic u, input logic [15:0] m);
        keep = r_flg;
        go(o, w, u, 16'h4c21, 16'h0003, m);
        cmp_bit(r_ill, 1'b1);
        cmp_bit(r_wr, 1'b0);
        cmp_val(r_res, 16'h4c21);
        cmp_val({8'h00, r_flg}, {8'h00, keep});
    endtask
    task t_add();
        go(op_plus, 1'b0, 1'b0, 16'hab7f, 16'h0001, 16'h0000);
        wrote(16'hab80);
        cmp_val({8'h00, r_flg}, 16'h002a);
        go(op_plus, 1'b1, 1'b0, 16'h1234, 16'hedcc, 16'h0000);
        wrote(16'h0000);
        cmp_bit(r_flg[`BWALU_FLAG_C], 1'b1);
        cmp_bit(r_flg[`BWALU_FLAG_Z], 1'b1);
        go(op_plus, 1'b0, 1'b1, 16'h0010, 16'h00ff, 16'h0005);
        wrote(16'h0015);
        go(op_minus, 1'b1, 1'b0, 16'h1000, 16'h0001, 16'h0000);
        wrote(16'h0fff);
    endtask
    task t_refuse();
        refused(op_minus, 1'b0, 1'b1, 16'h0001);
        refused(op_plus, 1'b1, 1'b1, 16'h0001);
        refused(op_minus, 1'b1, 1'b1, 16'h0001);
        refused(op_compare, 1'b1, 1'b1, 16'h0001);
        refused(op_add_with_carry, 1'b1, 1'b0, 16'h0001);
        refused(op_and, 1'b1, 1'b0, 16'h0001);
        refused(op_word_small_increment, 1'b1, 1'b1, 16'h0003);
        refused(op_word_small_decrement, 1'b1, 1'b1, 16'h0000);
    endtask
    task t_carry();
        go(op_plus, 1'b0, 1'b0, 16'h00ff, 16'h0001, 16'h0000);
        go(op_add_with_carry, 1'b0, 1'b1, 16'h0010, 16'h0000, 16'h0020);
        wrote(16'h0031);
        cmp_bit(r_flg[`BWALU_FLAG_C], 1'b0);
        go(op_plus, 1'b0, 1'b0, 16'h00ff, 16'h0002, 16'h0000);
        go(op_subtract_with_borrow, 1'b0, 1'b0, 16'h0010, 16'h0001, 16'h0000);
        wrote(16'h000e);
    endtask
    task t_step();
        go(op_plus_one, 1'b0, 1'b0, 16'h12ff, 16'h0000, 16'h0000);
        wrote(16'h1200);
        cmp_bit(r_flg[`BWALU_FLAG_Z], 1'b1);
        go(op_minus_one, 1'b0, 1'b0, 16'h3400, 16'h0000, 16'h0000);
        wrote(16'h34ff);
        go(op_word_small_increment, 1'b1, 1'b1, 16'hfffe, 16'h0000, 16'h0002);
        wrote(16'h0000);
        go(op_word_small_increment, 1'b1, 1'b1, 16'h00ff, 16'h0000, 16'h0001);
        wrote(16'h0100);
        go(op_word_small_decrement, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0002);
        wrote(16'hfffe);
    endtask
    task t_bcd();
        go(op_plus, 1'b0, 1'b0, 16'h0019, 16'h0028, 16'h0000);
        go(op_bcd_fix_after_plus, 1'b0, 1'b0, r_res, 16'h0000, 16'h0000);
        wrote(16'h0047);
        go(op_plus, 1'b0, 1'b0, 16'h0099, 16'h0001, 16'h0000);
        go(op_bcd_fix_after_plus, 1'b0, 1'b0, r_res, 16'h0000, 16'h0000);
        wrote(16'h0000);
        cmp_bit(r_flg[`BWALU_FLAG_C], 1'b1);
        go(op_minus, 1'b0, 1'b0, 16'h0042, 16'h0015, 16'h0000);
        go(op_bcd_fix_after_minus, 1'b0, 1'b0, r_res, 16'h0000, 16'h0000);
        wrote(16'h0027);
    endtask
    task t_muldiv();
        go(op_unsigned_multiply, 1'b0, 1'b0, 16'h77ff, 16'h88ff, 16'h0000);
        wrote(16'hfe01);
        go(op_unsigned_divide, 1'b0, 1'b0, 16'h0107, 16'h0010, 16'h0000);
        wrote(16'h0710);
        go(op_unsigned_divide, 1'b0, 1'b0, 16'h0107, 16'h0000, 16'h0000);
        cmp_bit(r_wr, 1'b0);
        cmp_bit(r_flg[`BWALU_FLAG_Z], 1'b1);
    endtask
    task t_cmp();
        go(op_compare, 1'b0, 1'b1, 16'h0005, 16'h0000, 16'h0005);
        cmp_bit(r_wr, 1'b0);
        cmp_bit(r_flg[`BWALU_FLAG_Z], 1'b1);
        go(op_compare, 1'b1, 1'b0, 16'h0100, 16'h0200, 16'h0000);
        cmp_bit(r_wr, 1'b0);
        cmp_bit(r_flg[`BWALU_FLAG_C], 1'b1);
    endtask
    task t_logic();
        bwalu_op_t lop[6];
        logic [7:0] lexp[6];
        lop = '{op_and, op_and, op_or, op_or, op_xor, op_xor};
        lexp = '{8'h05, 8'ha0, 8'haf, 8'hf5, 8'haa, 8'h55};
        for (int i = 0; i < 6; i++) begin
            go(lop[i], 1'b0, 1'(i % 2), 16'hc3a5, 16'h000f, 16'h00f0);
            wrote({8'hc3, lexp[i]});
        end
        go(op_not, 1'b0, 1'b0, 16'hc3a5, 16'h0000, 16'h0000);
        wrote(16'hc35a);
        go(op_twos_complement, 1'b0, 1'b0, 16'hc3a5, 16'h0000, 16'h0000);
        wrote(16'hc35b);
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_add();
        t_refuse();
        t_carry();
        t_step();
        t_bcd();
        t_muldiv();
        t_cmp();
        t_logic();
        close_out();
    end
endmodule
